// file: verif/aim_checker.sv
// concurrent checks for the alarm interrupt masking block
`timescale 1ns/1ps
module aim_checker (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_rdata,
  // interrupt pin
  input  wire logic       interrupt_out_n
);
  logic [7:0] m_a;
  logic [7:0] m_o;
  logic [7:0] m_b;
  logic [7:0] m_c;
  logic       all_mask;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // shadow of the mask registers, taken from bus writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      m_a <= 8'h00;
      m_o <= 8'h00;
      m_b <= 8'h00;
      m_c <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == 8'h17) m_a <= reg_wdata;
      if (reg_wr && reg_addr == 8'h18) m_o <= reg_wdata;
      if (reg_wr && reg_addr == 8'h19) m_b <= reg_wdata;
      if (reg_wr && reg_addr == 8'h1A) m_c <= reg_wdata;
    end
  end

  // every event source masked
  assign all_mask = (m_a & 8'h2F) == 8'h2F && m_o[7:4] == 4'hF && (m_b & 8'h22) == 8'h22
                    && m_c[5];

  ////////////////////////////////////////////////////////////////////////////
  // read data carry the mask as it stood at the read strobe, not after a later write
  AST_LOCK_MASK: assert property (reg_rd && reg_addr == 8'h19 |=>
    reg_rdata[1] == $past(m_b[1]))
    else $error("lock loss mask read back wrong");
  AST_HOLD_MASK: assert property (reg_rd && reg_addr == 8'h19 |=>
    reg_rdata[5] == $past(m_b[5]))
    else $error("holdover mask read back wrong");
  AST_CAL_MASK: assert property (reg_rd && reg_addr == 8'h1A |=>
    reg_rdata[5] == $past(m_c[5]))
    else $error("calibration mask read back wrong");
  AST_SYSCAL_MASK: assert property (reg_rd && reg_addr == 8'h17 |=>
    reg_rdata[0] == $past(m_a[0]))
    else $error("system cal mask read back wrong");
  AST_XLOSS_MASK: assert property (reg_rd && reg_addr == 8'h17 |=>
    reg_rdata[1] == $past(m_a[1]))
    else $error("crystal loss mask read back wrong");
  AST_REF_MASK: assert property (reg_rd && reg_addr == 8'h17 |=>
    reg_rdata[2] == $past(m_a[2]))
    else $error("reference loss mask read back wrong");
  AST_XERR_MASK: assert property (reg_rd && reg_addr == 8'h17 |=>
    reg_rdata[3] == $past(m_a[3]))
    else $error("crystal error mask read back wrong");
  AST_TMO_MASK: assert property (reg_rd && reg_addr == 8'h17 |=>
    reg_rdata[5] == $past(m_a[5]))
    else $error("timeout mask read back wrong");
  AST_OOF_MASK: assert property (reg_rd && reg_addr == 8'h18 |=>
    reg_rdata[7:4] == $past(m_o[7:4]))
    else $error("frequency fault masks read back wrong");
  AST_ALL_MASKED: assert property (all_mask && $past(all_mask) |-> interrupt_out_n)
    else $error("interrupt low with every event masked");
  // write edge updates state, pin follows one edge later, seen risen one edge after that
  AST_PIN_RISE: assert property ($rose(interrupt_out_n) |-> $past(reg_wr, 2))
    else $error("interrupt released without a register write");
endmodule

bind aim_top aim_checker u_aim_checker (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .interrupt_out_n(interrupt_out_n));

// file: verif/tb_aim_top.sv
// self-checking bench for the alarm interrupt masking block
`timescale 1ns/1ps
module tb_aim_top;
  localparam logic [7:0] MA [12] = '{8'h19, 8'h19, 8'h1A, 8'h17, 8'h17, 8'h17, 8'h17, 8'h17,
                                     8'h18, 8'h18, 8'h18, 8'h18};
  localparam int         MB [12] = '{1, 5, 5, 0, 1, 2, 3, 5, 4, 5, 6, 7};
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rd_q = 1'b0;
  logic [7:0]  reg_rdata;
  logic        interrupt_out_n;
  logic [11:0] ev = 12'h000;
  logic [7:0]  exp_q [$];
  logic [7:0]  fld_q [$];
  logic [7:0]  w;
  int          n_errors = 0;
  int          compares = 0;

  aim_top u_aim_top (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loss_of_lock(ev[0]),
    .holdover(ev[1]), .calibration(ev[2]), .sys_input_cal_event(ev[3]),
    .xtal_input_loss(ev[4]), .reference_loss(ev[5]), .xtal_error(ev[6]),
    .bus_timeout(ev[7]), .out_of_frequency(ev[11:8]), .interrupt_out_n(interrupt_out_n));

  // 100 ns clock
  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // bits that a register really holds
  function automatic logic [7:0] fld(input logic [7:0] a);
    case (a)
      8'h17: return 8'h2F;
      8'h18: return 8'hF0;
      8'h19: return 8'h22;
      8'h1A: return 8'h20;
      default: return 8'hFF;
    endcase
  endfunction

  // one-cycle bus write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle bus read, expectation noted
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] f);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    fld_q.push_back(f);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // read data compare on the held bits
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] e, input logic [7:0] f);
    compares++;
    if ((got & f) !== (e & f)) begin
      n_errors++;
      $display("BAD %0t read %h exp %h", $time, got, e);
    end
  endtask

  // interrupt pin compare, sampled mid-cycle
  task automatic pin_is(input logic e);
    @(negedge clk);
    compares++;
    if (interrupt_out_n !== e) begin
      n_errors++;
      $display("BAD %0t pin %h exp %h", $time, interrupt_out_n, e);
    end
    @(posedge clk);
  endtask

  // counts, verdict and end of run
  task automatic print_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watcher: oldest note against the read data
  always @(posedge clk) begin
    if (rd_q) cmp_rd(reg_rdata, exp_q.pop_front(), fld_q.pop_front());
    rd_q <= reg_rd;
  end

  // watchdog
  initial begin
    #(5000 * 100);
    n_errors++;
    print_verdict();
  end

  // main sequence
  initial begin
    void'($urandom(32'hE560D2ED));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    pin_is(1'b1);
    // reset values, then an unmapped place
    for (int j = 0; j < 4; j++) begin
      rd(8'h17 + 8'(j), 8'h00, fld(8'h17 + 8'(j)));
      @(posedge clk);
    end
    wr(8'h3C, 8'($urandom()));
    rd(8'h3C, 8'h00, 8'hFF);
    // each event masked, then unmasked, then cleared
    for (int i = 0; i < 12; i++) begin
      w = 8'($urandom()) | (8'h01 << MB[i]);
      wr(MA[i], w);
      rd(MA[i], w, fld(MA[i]));
      ev[i] <= 1'b1;
      repeat (10) @(posedge clk);
      pin_is(1'b1);
      rd(i < 8 ? 8'h1B : 8'h1C, 8'h01 << (i % 8), 8'hFF);
      wr(MA[i], 8'h00);
      repeat (2) @(posedge clk);
      pin_is(1'b0);
      ev[i] <= 1'b0;
      wr(i < 8 ? 8'h1B : 8'h1C, 8'h01 << (i % 8));
      repeat (2) @(posedge clk);
      pin_is(1'b1);
    end
    // everything masked with every event up, then one register opened
    for (int j = 0; j < 4; j++) begin
      wr(8'h17 + 8'(j), 8'hFF);
      @(posedge clk);
    end
    ev <= 12'hFFF;
    repeat (10) @(posedge clk);
    pin_is(1'b1);
    // live levels of every event, both bytes
    rd(8'h1D, 8'hFF, 8'hFF);
    @(posedge clk);
    rd(8'h1E, 8'h0F, 8'hFF);
    wr(8'h17, 8'h00);
    repeat (2) @(posedge clk);
    pin_is(1'b0);
    ev <= 12'h000;
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule

// file: verilog/aim_pkg.sv
// constants for the alarm interrupt masking block
package aim_pkg;
  // register offsets (byte addresses on the plain port)
  localparam logic [7:0] ADDR_MASK_A   = 8'h17; // sys cal, xtal loss, ref loss, xtal err, timeout
  localparam logic [7:0] ADDR_MASK_OOF = 8'h18; // out-of-frequency masks
  localparam logic [7:0] ADDR_MASK_B   = 8'h19; // lock loss, holdover
  localparam logic [7:0] ADDR_MASK_C   = 8'h1A; // calibration
  localparam logic [7:0] ADDR_STATUS   = 8'h1B; // sticky event status
  localparam logic [7:0] ADDR_EVENTS   = 8'h1D; // live event levels, two bytes, read only

  // field positions inside the mask registers
  localparam int BIT_SYS_CAL  = 0;
  localparam int BIT_XTAL_LOS = 1;
  localparam int BIT_REF_LOS  = 2;
  localparam int BIT_XTAL_ERR = 3;
  localparam int BIT_TIMEOUT  = 5;
  localparam int BIT_OOF_LO   = 4;
  localparam int BIT_LOCK     = 1;
  localparam int BIT_HOLD     = 5;
  localparam int BIT_CAL      = 5;

  // event vector layout (status register, bit per event)
  localparam int NUM_EVENTS   = 12;
  localparam int EV_LOCK      = 0;
  localparam int EV_HOLD      = 1;
  localparam int EV_CAL       = 2;
  localparam int EV_SYS_CAL   = 3;
  localparam int EV_XTAL_LOS  = 4;
  localparam int EV_REF_LOS   = 5;
  localparam int EV_XTAL_ERR  = 6;
  localparam int EV_TIMEOUT   = 7;
  localparam int EV_OOF_LO    = 8;
  localparam int NUM_OOF      = 4;

  // reset values: every event allowed
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
endpackage

// file: verilog/aim_sync.sv
// three-stage synchroniser with agreement filter, one per event input
`timescale 1ns/1ps
module aim_sync #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // asynchronous levels in, filtered levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // stage1 is read only by stage2
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change counts once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_filt
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          sync_out[i] <= 1'b0;
        end else if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  endgenerate
endmodule

// file: verilog/aim_top.sv
// alarm interrupt masking: mask registers, sticky status, interrupt pin
// Behaviour
// R1 - lock-loss mask resets to 0; a 1 keeps lock loss off the interrupt
// R2 - holdover/freerun mask resets to 0; a 1 blocks that condition
// R3 - calibration mask resets to 0; a 1 blocks calibration events
// R4 - system-input calibration mask resets to 0; a 1 blocks that event
// R5 - crystal-input loss mask resets to 0; a 1 blocks crystal loss
// R6 - reference-loss mask resets to 0; a 1 blocks reference loss
// R7 - crystal-error mask resets to 0; a 1 blocks crystal errors
// R8 - bus-timeout mask resets to 0; a 1 blocks bus timeouts
// R9 - four out-of-frequency masks reset to 0; each 1 blocks its input
// R10 - interrupt pin low while any unmasked event pends, else high
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module aim_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // alarm and status conditions, asynchronous levels
  input  wire logic        loss_of_lock,
  input  wire logic        holdover,
  input  wire logic        calibration,
  input  wire logic        sys_input_cal_event,
  input  wire logic        xtal_input_loss,
  input  wire logic        reference_loss,
  input  wire logic        xtal_error,
  input  wire logic        bus_timeout,
  input  wire logic [3:0]  out_of_frequency,
  // interrupt pin, active low
  output logic             interrupt_out_n
);

  localparam int NE = aim_pkg::NUM_EVENTS;

  ////////////////////////////////////////////////////////////////////////////
  // mask bits
  logic       lock_loss_irq_mask;
  logic       holdover_irq_mask;
  logic       calibration_irq_mask;
  logic       sys_cal_irq_mask;
  logic       xtal_loss_irq_mask;
  logic       ref_loss_irq_mask;
  logic       xtal_error_irq_mask;
  logic       bus_timeout_irq_mask;
  logic [3:0] freq_fault_irq_mask;

  // event path
  logic [NE-1:0] raw_events;
  logic [NE-1:0] live_events;
  logic [NE-1:0] live_prev;
  logic [NE-1:0] rise;
  logic [NE-1:0] mask_vec;
  logic [NE-1:0] status;
  logic [NE-1:0] clear_vec;
  logic [15:0]   status_wide;
  logic [15:0]   live_wide;
  logic [7:0]    next_rdata;
  logic [7:0]    reg_a;
  logic [7:0]    reg_b;
  logic [7:0]    reg_c;
  logic [7:0]    reg_oof;

  ////////////////////////////////////////////////////////////////////////////
  // gather event inputs in status order
  always_comb begin
    raw_events = '0;
    raw_events[aim_pkg::EV_LOCK]     = loss_of_lock;
    raw_events[aim_pkg::EV_HOLD]     = holdover;
    raw_events[aim_pkg::EV_CAL]      = calibration;
    raw_events[aim_pkg::EV_SYS_CAL]  = sys_input_cal_event;
    raw_events[aim_pkg::EV_XTAL_LOS] = xtal_input_loss;
    raw_events[aim_pkg::EV_REF_LOS]  = reference_loss;
    raw_events[aim_pkg::EV_XTAL_ERR] = xtal_error;
    raw_events[aim_pkg::EV_TIMEOUT]  = bus_timeout;
    raw_events[aim_pkg::EV_OOF_LO +: aim_pkg::NUM_OOF] = out_of_frequency;
  end

  // conditions come from other clock regions
  aim_sync #(
    .WIDTH (NE)
  ) u_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in (raw_events),
    .sync_out (live_events)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mask register at 0x17
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_cal_irq_mask     <= aim_pkg::MASK_RESET[0]; // R4
      xtal_loss_irq_mask   <= aim_pkg::MASK_RESET[0]; // R5
      ref_loss_irq_mask    <= aim_pkg::MASK_RESET[0]; // R6
      xtal_error_irq_mask  <= aim_pkg::MASK_RESET[0]; // R7
      bus_timeout_irq_mask <= aim_pkg::MASK_RESET[0]; // R8
    end else if (reg_wr && reg_addr == aim_pkg::ADDR_MASK_A) begin
      sys_cal_irq_mask     <= reg_wdata[aim_pkg::BIT_SYS_CAL];  // R4
      xtal_loss_irq_mask   <= reg_wdata[aim_pkg::BIT_XTAL_LOS]; // R5
      ref_loss_irq_mask    <= reg_wdata[aim_pkg::BIT_REF_LOS];  // R6
      xtal_error_irq_mask  <= reg_wdata[aim_pkg::BIT_XTAL_ERR]; // R7
      bus_timeout_irq_mask <= reg_wdata[aim_pkg::BIT_TIMEOUT];  // R8
    end
  end

  // out-of-frequency mask register at 0x18
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      freq_fault_irq_mask <= aim_pkg::MASK_RESET[3:0]; // R9
    end else if (reg_wr && reg_addr == aim_pkg::ADDR_MASK_OOF) begin
      freq_fault_irq_mask <= reg_wdata[aim_pkg::BIT_OOF_LO +: aim_pkg::NUM_OOF]; // R9
    end
  end

  // lock and holdover mask register at 0x19
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_loss_irq_mask <= aim_pkg::MASK_RESET[0]; // R1
      holdover_irq_mask  <= aim_pkg::MASK_RESET[0]; // R2
    end else if (reg_wr && reg_addr == aim_pkg::ADDR_MASK_B) begin
      lock_loss_irq_mask <= reg_wdata[aim_pkg::BIT_LOCK]; // R1
      holdover_irq_mask  <= reg_wdata[aim_pkg::BIT_HOLD]; // R2
    end
  end

  // calibration mask register at 0x1A
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      calibration_irq_mask <= aim_pkg::MASK_RESET[0]; // R3
    end else if (reg_wr && reg_addr == aim_pkg::ADDR_MASK_C) begin
      calibration_irq_mask <= reg_wdata[aim_pkg::BIT_CAL]; // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mask bits in event order
  always_comb begin
    mask_vec = '0;
    mask_vec[aim_pkg::EV_LOCK]     = lock_loss_irq_mask;   // R1
    mask_vec[aim_pkg::EV_HOLD]     = holdover_irq_mask;    // R2
    mask_vec[aim_pkg::EV_CAL]      = calibration_irq_mask; // R3
    mask_vec[aim_pkg::EV_SYS_CAL]  = sys_cal_irq_mask;     // R4
    mask_vec[aim_pkg::EV_XTAL_LOS] = xtal_loss_irq_mask;   // R5
    mask_vec[aim_pkg::EV_REF_LOS]  = ref_loss_irq_mask;    // R6
    mask_vec[aim_pkg::EV_XTAL_ERR] = xtal_error_irq_mask;  // R7
    mask_vec[aim_pkg::EV_TIMEOUT]  = bus_timeout_irq_mask; // R8
    mask_vec[aim_pkg::EV_OOF_LO +: aim_pkg::NUM_OOF] = freq_fault_irq_mask; // R9
  end

  // previous filtered level for rising-edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      live_prev <= '0;
    end else begin
      live_prev <= live_events;
    end
  end

  assign rise = live_events & ~live_prev;

  // write-one-to-clear strobes, status spread over two bytes
  always_comb begin
    clear_vec = '0;
    if (reg_wr && reg_addr == aim_pkg::ADDR_STATUS) begin
      clear_vec[7:0] = reg_wdata;
    end else if (reg_wr && reg_addr == aim_pkg::ADDR_STATUS + 8'h01) begin
      clear_vec[NE-1:8] = reg_wdata[NE-9:0];
    end
  end

  // sticky status; a new edge wins over a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < NE; gi++) begin : g_status
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          status[gi] <= 1'b0;
        end else if (rise[gi]) begin
          status[gi] <= 1'b1;
        end else if (clear_vec[gi]) begin
          status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin, low while any unmasked sticky bit is set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= ~|(status & ~mask_vec); // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    reg_a = '0;
    reg_a[aim_pkg::BIT_SYS_CAL]  = sys_cal_irq_mask;
    reg_a[aim_pkg::BIT_XTAL_LOS] = xtal_loss_irq_mask;
    reg_a[aim_pkg::BIT_REF_LOS]  = ref_loss_irq_mask;
    reg_a[aim_pkg::BIT_XTAL_ERR] = xtal_error_irq_mask;
    reg_a[aim_pkg::BIT_TIMEOUT]  = bus_timeout_irq_mask;
    reg_oof = '0;
    reg_oof[aim_pkg::BIT_OOF_LO +: aim_pkg::NUM_OOF] = freq_fault_irq_mask;
    reg_b = '0;
    reg_b[aim_pkg::BIT_LOCK] = lock_loss_irq_mask;
    reg_b[aim_pkg::BIT_HOLD] = holdover_irq_mask;
    reg_c = '0;
    reg_c[aim_pkg::BIT_CAL] = calibration_irq_mask;
    status_wide = {{(16 - NE){1'b0}}, status};
    live_wide   = {{(16 - NE){1'b0}}, live_events};
    case (reg_addr)
      aim_pkg::ADDR_MASK_A:           next_rdata = reg_a;
      aim_pkg::ADDR_MASK_OOF:         next_rdata = reg_oof;
      aim_pkg::ADDR_MASK_B:           next_rdata = reg_b;
      aim_pkg::ADDR_MASK_C:           next_rdata = reg_c;
      aim_pkg::ADDR_STATUS:           next_rdata = status_wide[7:0];
      aim_pkg::ADDR_STATUS + 8'h01:   next_rdata = status_wide[15:8];
      aim_pkg::ADDR_EVENTS:           next_rdata = live_wide[7:0];
      aim_pkg::ADDR_EVENTS + 8'h01:   next_rdata = live_wide[15:8];
      default:                        next_rdata = 8'h00; // unmapped reads zero
    endcase
  end

  // read data valid in the cycle after the strobe only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule
